// ### common/vkl_pkg.sv
/*
  Constants, register map and enumerations for the video keyer layer.
  Assumes one 100 MHz clock and an Avalon-MM slave with 32-bit data.
*/
package vkl_pkg;
  // ----------------------------------------
  // Widths and ranges
  // ----------------------------------------
  localparam int unsigned VW = 10;
  localparam logic [9:0] KEY_BLACK = 10'h040;
  localparam logic [9:0] KEY_WHITE = 10'h3ac;
  localparam logic [9:0] KEY_SPAN  = 10'h36c;
  localparam logic [9:0] TRANS_MAX = 10'h200;
  localparam logic [9:0] RATE_MIN  = 10'h001;
  localparam logic [9:0] RATE_MAX  = 10'h3e7;
  localparam logic [11:0] HRES     = 12'h780;
  localparam logic [11:0] VRES     = 12'h438;
  localparam logic [9:0] MIX_FULL  = 10'h200;
  localparam int unsigned MIX_SH   = 9;
  localparam int unsigned NPAIR    = 3;
  localparam logic [15:0] MEM_CAP  = 16'h1000;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] A_CTRL   = 6'h00;
  localparam logic [5:0] A_CMD    = 6'h04;
  localparam logic [5:0] A_SHAPE  = 6'h08;
  localparam logic [5:0] A_TRANS  = 6'h0c;
  localparam logic [5:0] A_RATE   = 6'h10;
  localparam logic [5:0] A_POS    = 6'h14;
  localparam logic [5:0] A_IMG    = 6'h18;
  localparam logic [5:0] A_STAT   = 6'h1c;
  localparam logic [5:0] A_ANIM   = 6'h20;
  // ----------------------------------------
  // Command codes written to A_CMD
  // ----------------------------------------
  localparam logic [4:0] C_CUT_TGL  = 5'h01;
  localparam logic [4:0] C_CUT_UP   = 5'h02;
  localparam logic [4:0] C_CUT_DN   = 5'h03;
  localparam logic [4:0] C_FADE_TGL = 5'h04;
  localparam logic [4:0] C_FADE_UP  = 5'h05;
  localparam logic [4:0] C_FADE_DN  = 5'h06;
  localparam logic [4:0] C_SEL1     = 5'h07;
  localparam logic [4:0] C_SEL2     = 5'h08;
  localparam logic [4:0] C_SEL3     = 5'h09;
  localparam logic [4:0] C_UNLOAD   = 5'h0a;
  localparam logic [4:0] C_SAVE     = 5'h0b;
  localparam logic [4:0] C_LOAD     = 5'h0c;
  localparam logic [4:0] C_PLAY     = 5'h0d;
  localparam logic [4:0] C_RESTART  = 5'h0e;
  localparam logic [4:0] C_STOP     = 5'h0f;
  localparam logic [4:0] C_STOP_NOW = 5'h10;
  // ----------------------------------------
  // Control field positions in A_CTRL
  // ----------------------------------------
  localparam int unsigned F_SRC  = 0;
  localparam int unsigned F_FULL = 2;
  localparam int unsigned F_INV  = 3;
  localparam int unsigned F_MASK = 4;
  localparam int unsigned F_CUTL = 5;
  // Key sources
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_SELF = 2'h1;
  localparam logic [1:0] SRC_SEP  = 2'h2;
  localparam logic [5:0] CTRL_RST = 6'h05;
  typedef enum logic [1:0] {
    FD_IDLE = 2'b00,
    FD_UP   = 2'b01,
    FD_DOWN = 2'b10
  } vkl_fade_t;
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b00,
    LD_CLEAN = 2'b01,
    LD_CUT   = 2'b10
  } vkl_load_t;
endpackage

// ### rtl/vkl_keyer_layer.sv
/*
  Keyer layer: key shaping, fill/background mix, black cut and fade,
  input pair recall, image load control and animation transport.
  Assumes pixel streams synchronous to clk, a one-cycle vblank pulse
  per field, and a store that reports load done and frame counts.
*/
`timescale 1ns/1ns
// How it works
// RL1: Keys below clip level are forced to black.
// RL2: Key is amplified by gain, grey pushed toward white.
// RL3: Clip and gain accepted only from 64 to 940.
// RL4: Transparency 0..512 scales the maximum key level.
// RL5: Controller should program clip 64, gain 940, transparency 512.
// RL6: Cut toggle swaps output between black and picture instantly.
// RL7: Cut from black shows picture instantly.
// RL8: Cut to black shows black instantly.
// RL9: Fade toggle ramps in the needed direction over fade duration.
// RL10: Fade from black ramps picture up over fade duration.
// RL11: Fade to black ramps picture down over fade duration.
// RL12: Fade duration in fields, 1 to 999.
// RL13: Selecting a pair reloads its saved key parameters.
// RL14: Unload detaches the keyer input.
// RL15: Image position signed, within plus/minus resolution.
// RL16: Save stores key parameters, per pair when a pair is selected; with no pair selected the code stores nothing.
// RL17: Clean load clears store and hides image until loaded.
// RL18: Cut load shows old image until new one loaded, then cuts.
// RL19: Cut load fails when both images exceed memory capacity.
// RL20: Play resumes animation from the frame where it stopped.
// RL21: Restart plays from the first frame.
// RL22: Normal stop runs to final frame; immediate stop halts now.
// RL23: Cuts and fade starts take effect at vertical interval.
// RL24: Key from fill or separate key luma; none gives white.
// RL25: Inverted sense uses one minus the key.
// RL26: Full mixes fill*k + bg*(1-k); linear adds fill + bg*(1-k).
// RL27: Fade steps equally each field, ending at the field count.
// RL28: Shaping order clip, gain, transparency; 512 passes unchanged.
module vkl_keyer_layer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        vblank,
  input  wire logic [9:0]  fill_y,
  input  wire logic [9:0]  key_y,
  input  wire logic [9:0]  bg_y,
  input  wire logic        load_done,
  input  wire logic [15:0] new_img_size,
  input  wire logic [15:0] anim_last,
  output logic [9:0]       out_y,
  output logic             store_clear,
  output logic             store_load,
  output logic             show_new,
  output logic [1:0]       input_sel,
  output logic [15:0]      anim_frame
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [5:0]  ctrl_q;
  logic [9:0]  clip_q, gain_q, trans_q, rate_q;
  logic [11:0] hpos_q, vpos_q;
  logic [15:0] res_size_q;
  logic [1:0]  sel_q;
  localparam int NPAIR_I = vkl_pkg::NPAIR;
  logic [5:0]  pair_ctrl_q [NPAIR_I];
  logic [9:0]  pair_clip_q [NPAIR_I];
  logic [9:0]  pair_gain_q [NPAIR_I];
  logic [9:0]  pair_trans_q [NPAIR_I];
  logic        up_q, load_fail_q, playing_q, stop_end_q, ack_q;
  logic [4:0]  pend_q;
  logic [9:0]  mix_q, fld_q;
  logic [19:0] step_acc;
  vkl_pkg::vkl_fade_t fade_q;
  vkl_pkg::vkl_load_t load_q;
  logic        wr, cmd;
  logic [4:0]  code;
  // Write lands on the edge where waitrequest is seen low
  assign wr   = avs_write && ack_q;
  assign cmd  = wr && avs_address == vkl_pkg::A_CMD;
  assign code = avs_writedata[4:0];
  // ----------------------------------------
  // Bus slave: one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        vkl_pkg::A_CTRL:  avs_readdata <= {26'h0, ctrl_q};
        vkl_pkg::A_SHAPE: avs_readdata <= {6'h0, gain_q, 6'h0, clip_q};
        vkl_pkg::A_TRANS: avs_readdata <= {22'h0, trans_q};
        vkl_pkg::A_RATE:  avs_readdata <= {22'h0, rate_q};
        vkl_pkg::A_POS:   avs_readdata <= {4'h0, vpos_q, 4'h0, hpos_q};
        vkl_pkg::A_STAT:  avs_readdata <= {12'h0, mix_q, 2'h0, sel_q, load_q,
                                           load_fail_q, up_q, fade_q};
        vkl_pkg::A_ANIM:  avs_readdata <= {14'h0, stop_end_q, playing_q, anim_frame};
        default:          avs_readdata <= 32'h0;
      endcase
    end
  end
  // ----------------------------------------
  // Parameter registers and pair recall
  // ----------------------------------------
  function automatic logic in_range(input logic [9:0] v);
    in_range = v >= vkl_pkg::KEY_BLACK && v <= vkl_pkg::KEY_WHITE;
  endfunction
  function automatic logic pos_ok(input logic [11:0] v, input logic [11:0] lim);
    pos_ok = v[11] ? (12'(-v) <= lim) : (v <= lim);
  endfunction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= vkl_pkg::CTRL_RST;
      clip_q  <= vkl_pkg::KEY_BLACK;
      gain_q  <= vkl_pkg::KEY_WHITE;
      trans_q <= vkl_pkg::TRANS_MAX;
      rate_q  <= vkl_pkg::RATE_MIN;
      hpos_q  <= 12'h0;
      vpos_q  <= 12'h0;
      sel_q   <= 2'h0;
    end else if (cmd && (code == vkl_pkg::C_SEL1 || code == vkl_pkg::C_SEL2
                         || code == vkl_pkg::C_SEL3)) begin
      // RL13: pair recall
      sel_q   <= 2'(code - vkl_pkg::C_SEL1 + 5'h01);
      ctrl_q  <= pair_ctrl_q[2'(code - vkl_pkg::C_SEL1)];
      clip_q  <= pair_clip_q[2'(code - vkl_pkg::C_SEL1)];
      gain_q  <= pair_gain_q[2'(code - vkl_pkg::C_SEL1)];
      trans_q <= pair_trans_q[2'(code - vkl_pkg::C_SEL1)];
    end else if (cmd && code == vkl_pkg::C_UNLOAD) begin
      // RL14: detach input
      sel_q <= 2'h0;
    end else if (wr) begin
      case (avs_address)
        vkl_pkg::A_CTRL: ctrl_q <= avs_writedata[5:0];
        vkl_pkg::A_SHAPE: begin
          // RL3: range check
          if (in_range(avs_writedata[9:0])) clip_q <= avs_writedata[9:0];
          if (in_range(avs_writedata[25:16])) gain_q <= avs_writedata[25:16];
        end
        vkl_pkg::A_TRANS: begin
          // RL4: transparency range
          if (avs_writedata[9:0] <= vkl_pkg::TRANS_MAX) trans_q <= avs_writedata[9:0];
        end
        vkl_pkg::A_RATE: begin
          // RL12: duration range
          if (avs_writedata[9:0] >= vkl_pkg::RATE_MIN &&
              avs_writedata[9:0] <= vkl_pkg::RATE_MAX) rate_q <= avs_writedata[9:0];
        end
        vkl_pkg::A_POS: begin
          // RL15: position bounds
          if (pos_ok(avs_writedata[11:0], vkl_pkg::HRES)) hpos_q <= avs_writedata[11:0];
          if (pos_ok(avs_writedata[27:16], vkl_pkg::VRES)) vpos_q <= avs_writedata[27:16];
        end
        default: ;
      endcase
    end
  end
  // RL16: per-pair save
  genvar gi;
  generate
    for (gi = 0; gi < NPAIR_I; gi++) begin : g_pair
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pair_ctrl_q[gi]  <= vkl_pkg::CTRL_RST;
          pair_clip_q[gi]  <= vkl_pkg::KEY_BLACK;
          pair_gain_q[gi]  <= vkl_pkg::KEY_WHITE;
          pair_trans_q[gi] <= vkl_pkg::TRANS_MAX;
        end else if (cmd && code == vkl_pkg::C_SAVE && sel_q == 2'(gi + 1)) begin
          pair_ctrl_q[gi]  <= ctrl_q;
          pair_clip_q[gi]  <= clip_q;
          pair_gain_q[gi]  <= gain_q;
          pair_trans_q[gi] <= trans_q;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Black cut and fade control
  // ----------------------------------------
  // RL23: commands wait for vblank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 5'h0;
    end else if (cmd && code >= vkl_pkg::C_CUT_TGL && code <= vkl_pkg::C_FADE_DN) begin
      pend_q <= code;
    end else if (vblank) begin
      pend_q <= 5'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q   <= 1'b0;
      fade_q <= vkl_pkg::FD_IDLE;
      fld_q  <= 10'h0;
      mix_q  <= 10'h0;
    end else if (vblank) begin
      case (pend_q)
        // RL6: cut toggle
        vkl_pkg::C_CUT_TGL: begin
          up_q <= !up_q; mix_q <= up_q ? 10'h0 : vkl_pkg::MIX_FULL;
          fade_q <= vkl_pkg::FD_IDLE;
        end
        // RL7: cut up
        vkl_pkg::C_CUT_UP: begin
          up_q <= 1'b1; mix_q <= vkl_pkg::MIX_FULL; fade_q <= vkl_pkg::FD_IDLE;
        end
        // RL8: cut down
        vkl_pkg::C_CUT_DN: begin
          up_q <= 1'b0; mix_q <= 10'h0; fade_q <= vkl_pkg::FD_IDLE;
        end
        // RL9: fade toggle
        vkl_pkg::C_FADE_TGL: begin
          up_q <= !up_q; fld_q <= 10'h0;
          fade_q <= up_q ? vkl_pkg::FD_DOWN : vkl_pkg::FD_UP;
        end
        // RL10: fade up
        vkl_pkg::C_FADE_UP: begin
          up_q <= 1'b1; fld_q <= 10'h0; fade_q <= vkl_pkg::FD_UP;
        end
        // RL11: fade down
        vkl_pkg::C_FADE_DN: begin
          up_q <= 1'b0; fld_q <= 10'h0; fade_q <= vkl_pkg::FD_DOWN;
        end
        default: begin
          // RL27: linear step per field
          if (fade_q != vkl_pkg::FD_IDLE) begin
            fld_q <= fld_q + 10'h1;
            if (fld_q + 10'h1 >= rate_q) begin
              fade_q <= vkl_pkg::FD_IDLE;
              mix_q  <= (fade_q == vkl_pkg::FD_UP) ? vkl_pkg::MIX_FULL : 10'h0;
            end else begin
              mix_q <= (fade_q == vkl_pkg::FD_UP) ? 10'(step_acc / 20'(rate_q))
                       : 10'(vkl_pkg::MIX_FULL - 10'(step_acc / 20'(rate_q)));
            end
          end
        end
      endcase
    end
  end
  assign step_acc = 20'(fld_q + 10'h1) * 20'(vkl_pkg::MIX_FULL);
  // ----------------------------------------
  // Image load and animation
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= vkl_pkg::LD_IDLE; load_fail_q <= 1'b0; res_size_q <= 16'h0;
      store_clear <= 1'b0; store_load <= 1'b0; show_new <= 1'b0;
    end else begin
      store_clear <= 1'b0;
      show_new    <= 1'b0;
      case (load_q)
        vkl_pkg::LD_IDLE: if (cmd && code == vkl_pkg::C_LOAD) begin
          if (ctrl_q[vkl_pkg::F_CUTL]) begin
            // RL19: capacity check
            if (17'(res_size_q) + 17'(new_img_size) > 17'(vkl_pkg::MEM_CAP)) begin
              load_fail_q <= 1'b1;
            end else begin
              load_fail_q <= 1'b0; store_load <= 1'b1; load_q <= vkl_pkg::LD_CUT;
            end
          end else begin
            // RL17: clear and start load in the same cycle
            load_fail_q <= 1'b0; store_clear <= 1'b1; store_load <= 1'b1;
            res_size_q <= 16'h0; load_q <= vkl_pkg::LD_CLEAN;
          end
        end
        vkl_pkg::LD_CLEAN, vkl_pkg::LD_CUT: if (load_done) begin
          // RL18: swap after load
          store_load <= 1'b0; show_new <= 1'b1;
          res_size_q <= new_img_size; load_q <= vkl_pkg::LD_IDLE;
        end
        default: load_q <= vkl_pkg::LD_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      playing_q <= 1'b0; stop_end_q <= 1'b0; anim_frame <= 16'h0;
    end else if (cmd && code == vkl_pkg::C_PLAY) begin
      // RL20: resume
      playing_q <= 1'b1; stop_end_q <= 1'b0;
    end else if (cmd && code == vkl_pkg::C_RESTART) begin
      // RL21: first frame
      playing_q <= 1'b1; stop_end_q <= 1'b0; anim_frame <= 16'h0;
    end else if (cmd && code == vkl_pkg::C_STOP_NOW) begin
      // RL22: immediate stop
      playing_q <= 1'b0;
    end else if (cmd && code == vkl_pkg::C_STOP) begin
      stop_end_q <= 1'b1;
    end else if (vblank && playing_q) begin
      // RL22: run to last frame
      if (anim_frame == anim_last) begin
        if (stop_end_q) playing_q <= 1'b0;
        else anim_frame <= 16'h0;
      end else begin
        anim_frame <= anim_frame + 16'h1;
      end
    end
  end
  // ----------------------------------------
  // Key shaping and mixing
  // ----------------------------------------
  logic [9:0]  k_raw, k_clip, k_gain, k_tr, k_fin;
  logic [20:0] g_prod;
  logic [19:0] t_prod;
  logic [19:0] f_part, b_part;
  logic [10:0] pic;
  always_comb begin
    // RL24: key source
    case (ctrl_q[vkl_pkg::F_SRC +: 2])
      vkl_pkg::SRC_SELF: k_raw = fill_y;
      vkl_pkg::SRC_SEP:  k_raw = key_y;
      default:           k_raw = vkl_pkg::KEY_WHITE;
    endcase
    // RL1: clip
    k_clip = (k_raw < clip_q) ? 10'h0 : 10'(k_raw - clip_q);
    // RL2: gain
    g_prod = 21'(k_clip) * 21'(gain_q) / 21'(vkl_pkg::KEY_SPAN);
    k_gain = (g_prod > 21'(vkl_pkg::MIX_FULL)) ? vkl_pkg::MIX_FULL : 10'(g_prod);
    // RL28: transparency normalised
    t_prod = 20'(k_gain) * 20'(trans_q);
    k_tr   = 10'(t_prod >> vkl_pkg::MIX_SH);
    // RL25: invert
    k_fin  = ctrl_q[vkl_pkg::F_INV] ? 10'(vkl_pkg::MIX_FULL - k_tr) : k_tr;
    if (sel_q == 2'h0) k_fin = 10'h0;
    // RL26: full or linear
    f_part = ctrl_q[vkl_pkg::F_FULL] ? 20'(fill_y) * 20'(k_fin)
             : (sel_q == 2'h0 ? 20'h0 : 20'(fill_y) << vkl_pkg::MIX_SH);
    b_part = 20'(bg_y) * 20'(10'(vkl_pkg::MIX_FULL - k_fin));
    pic    = 11'((f_part + b_part) >> vkl_pkg::MIX_SH);
    if (pic > 11'(vkl_pkg::KEY_WHITE)) pic = 11'(vkl_pkg::KEY_WHITE);
  end
  // RL6: output black or picture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_y <= vkl_pkg::KEY_BLACK;
    end else begin
      out_y <= 10'(((20'(pic) * 20'(mix_q)) + (20'(vkl_pkg::KEY_BLACK)
               * 20'(10'(vkl_pkg::MIX_FULL - mix_q)))) >> vkl_pkg::MIX_SH);
    end
  end
  assign input_sel = sel_q;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CLIP_RANGE: assert property (clip_q >= vkl_pkg::KEY_BLACK) // RL3
    else $error("clip out of range");
  AST_RATE_RANGE: assert property (rate_q >= vkl_pkg::RATE_MIN) // RL12
    else $error("fade duration out of range");
  AST_CUT_UP: assert property (vblank && pend_q == vkl_pkg::C_CUT_UP // RL7
    |=> mix_q == vkl_pkg::MIX_FULL) else $error("cut up missed");
  AST_CUT_DN: assert property (vblank && pend_q == vkl_pkg::C_CUT_DN // RL8
    |=> mix_q == 10'h0) else $error("cut down missed");
  AST_SEL_RECALL: assert property (cmd && code == vkl_pkg::C_SEL1 // RL13
    |=> clip_q == $past(pair_clip_q[0])) else $error("pair recall missed");
  AST_UNLOAD: assert property (cmd && code == vkl_pkg::C_UNLOAD // RL14
    |=> sel_q == 2'h0) else $error("unload missed");
  AST_RESTART: assert property (cmd && code == vkl_pkg::C_RESTART // RL21
    |=> anim_frame == 16'h0 && playing_q) else $error("restart missed");
  AST_STOP_NOW: assert property (cmd && code == vkl_pkg::C_STOP_NOW // RL22
    |=> !playing_q) else $error("immediate stop missed");
  AST_CLEAN: assert property (load_q == vkl_pkg::LD_CLEAN && !load_done // RL17
    |=> !show_new) else $error("image shown before load done");
endmodule

// ### tb/vkl_keyer_layer_tb_top.sv
/*
  Bench for the keyer layer: registers, black cuts and fades, key
  shaping, pair recall, image loads and animation transport.
  Assumes a one-wait-cycle Avalon-MM slave and a field pulse model.
*/
`timescale 1ns/1ns
module vkl_keyer_layer_tb_top;
  logic        clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        vblank;
  logic [9:0]  fill_y;
  logic [9:0]  key_y;
  logic [9:0]  bg_y;
  logic [9:0]  key_set;
  logic        load_done;
  logic [15:0] new_img_size;
  logic [15:0] anim_last;
  logic [9:0]  out_y;
  logic        store_clear;
  logic        store_load;
  logic        show_new;
  logic [1:0]  input_sel;
  logic [15:0] anim_frame;
  logic [31:0] q;
  logic [15:0] f;
  int          bad_count;
  int          check_count;
  int          clr_n;
  int          new_n;

  vkl_keyer_layer uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .vblank(vblank), .fill_y(fill_y), .key_y(key_y), .bg_y(bg_y),
    .load_done(load_done), .new_img_size(new_img_size), .anim_last(anim_last),
    .out_y(out_y), .store_clear(store_clear), .store_load(store_load),
    .show_new(show_new), .input_sel(input_sel), .anim_frame(anim_frame));
  vkl_src_model model (.clk(clk), .rst_n(rst_n), .fill_set(10'h1f4),
    .key_set(key_set), .bg_set(10'h0c8), .store_load(store_load),
    .vblank(vblank), .fill_y(fill_y), .key_y(key_y), .bg_y(bg_y),
    .load_done(load_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (store_clear === 1'b1) clr_n++;
    if (show_new === 1'b1) new_n++;
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic fields(input int n);
    repeat (n) @(posedge vblank);
    repeat (4) @(posedge clk);
  endtask
  task automatic act(input logic [4:0] c, input int n, input logic [9:0] e);
    logic [9:0] p;
    fields(1);
    p = out_y;
    wr(vkl_pkg::A_CMD, 32'(c));
    chk("out_y held", 32'(p), 32'(out_y));
    fields(n);
    chk("out_y", 32'(e), 32'(out_y));
  endtask
  task automatic mix(input logic [5:0] c, input logic [9:0] k, input logic [9:0] e);
    wr(vkl_pkg::A_CTRL, 32'(c));
    key_set <= k;
    repeat (8) @(posedge clk);
    chk("out_y mix", 32'(e), 32'(out_y));
  endtask
  task automatic wait_new(input int t);
    int n;
    n = 0;
    while (new_n < t && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("show_new pulses", 32'(t), 32'(new_n));
  endtask
  task automatic close_out;
    $display("Checks made %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    key_set = 10'h3ac;
    new_img_size = 16'h0c00;
    anim_last = 16'h0005;
    bad_count = 0;
    check_count = 0;
    clr_n = 0;
    new_n = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(vkl_pkg::A_CTRL, 32'h5, "ctrl");
    rd(vkl_pkg::A_SHAPE, 32'h03ac_0040, "shape");
    rd(vkl_pkg::A_RATE, 32'h1, "rate");
    rd(6'h3c, 32'h0, "unmapped");
    wr(vkl_pkg::A_SHAPE, 32'h03ac_003f);
    wr(vkl_pkg::A_SHAPE, 32'h03ad_0040);
    rd(vkl_pkg::A_SHAPE, 32'h03ac_0040, "shape kept");
    wr(vkl_pkg::A_TRANS, 32'h201);
    rd(vkl_pkg::A_TRANS, 32'h200, "trans kept");
    wr(vkl_pkg::A_RATE, 32'h0);
    wr(vkl_pkg::A_RATE, 32'h3e8);
    rd(vkl_pkg::A_RATE, 32'h1, "rate kept");
    wr(vkl_pkg::A_POS, 32'h0bc8_0880);
    wr(vkl_pkg::A_POS, 32'h0bc8_0781);
    rd(vkl_pkg::A_POS, 32'h0bc8_0880, "position");
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SEL1));
    wr(vkl_pkg::A_CTRL, 32'h06);
    act(vkl_pkg::C_CUT_UP, 1, 10'h1f4);
    act(vkl_pkg::C_CUT_DN, 1, 10'h040);
    act(vkl_pkg::C_CUT_TGL, 1, 10'h1f4);
    act(vkl_pkg::C_CUT_TGL, 1, 10'h040);
    wr(vkl_pkg::A_RATE, 32'h2);
    fields(1);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_FADE_UP));
    fields(2);
    bus(1'b0, vkl_pkg::A_STAT, 32'h0);
    chk("mix half", 32'h100, 32'(q[19:10]));
    fields(1);
    chk("out_y faded", 32'h1f4, 32'(out_y));
    wr(vkl_pkg::A_RATE, 32'h1);
    act(vkl_pkg::C_FADE_DN, 2, 10'h040);
    act(vkl_pkg::C_FADE_TGL, 2, 10'h1f4);
    mix(6'h06, 10'h3ac, 10'h1f4);
    mix(6'h06, 10'h040, 10'h0c8);
    mix(6'h0e, 10'h3ac, 10'h0c8);
    mix(6'h04, 10'h040, 10'h1f4);
    mix(6'h02, 10'h040, 10'h2bc);
    mix(6'h06, 10'h23c, 10'h1f4);
    wr(vkl_pkg::A_SHAPE, 32'h036c_0040);
    mix(6'h06, 10'h23c, 10'h1f1);
    wr(vkl_pkg::A_SHAPE, 32'h03ac_0258);
    mix(6'h06, 10'h1f4, 10'h0c8);
    wr(vkl_pkg::A_SHAPE, 32'h03ac_0040);
    wr(vkl_pkg::A_TRANS, 32'h0);
    mix(6'h06, 10'h3ac, 10'h0c8);
    wr(vkl_pkg::A_TRANS, 32'h200);
    mix(6'h06, 10'h3ac, 10'h1f4);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SEL1));
    wr(vkl_pkg::A_TRANS, 32'h0);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SAVE));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SEL2));
    wr(vkl_pkg::A_TRANS, 32'h200);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SAVE));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SEL1));
    rd(vkl_pkg::A_TRANS, 32'h0, "recall pair 1");
    chk("input_sel", 32'h1, 32'(input_sel));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SEL2));
    rd(vkl_pkg::A_TRANS, 32'h200, "recall pair 2");
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_SEL3));
    chk("input_sel", 32'h3, 32'(input_sel));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_UNLOAD));
    repeat (8) @(posedge clk);
    chk("input_sel", 32'h0, 32'(input_sel));
    chk("out_y unloaded", 32'h0c8, 32'(out_y));
    wr(vkl_pkg::A_CTRL, 32'h06);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_LOAD));
    repeat (3) @(posedge clk);
    chk("clear pulses", 32'h1, 32'(clr_n));
    chk("shown early", 32'h0, 32'(new_n));
    chk("store_load", 32'h1, 32'(store_load));
    wait_new(1);
    new_img_size <= 16'h0200;
    wr(vkl_pkg::A_CTRL, 32'h26);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_LOAD));
    repeat (3) @(posedge clk);
    chk("shown early", 32'h1, 32'(new_n));
    wait_new(2);
    chk("clear pulses", 32'h1, 32'(clr_n));
    new_img_size <= 16'h0f00;
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_LOAD));
    repeat (30) @(posedge clk);
    bus(1'b0, vkl_pkg::A_STAT, 32'h0);
    chk("load fail", 32'h1, 32'(q[3]));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_PLAY));
    fields(2);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_RESTART));
    chk("frame restart", 32'h0, 32'(anim_frame));
    fields(2);
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_STOP_NOW));
    f = anim_frame;
    fields(2);
    chk("frame held", 32'(f), 32'(anim_frame));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_PLAY));
    fields(1);
    chk("frame resumed", 32'(f + 16'h1), 32'(anim_frame));
    wr(vkl_pkg::A_CMD, 32'(vkl_pkg::C_STOP));
    fields(8);
    chk("frame at end", 32'h5, 32'(anim_frame));
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule

// ### tb/vkl_src_model.sv
/*
  Video source and image store model for the keyer layer.
  Assumes the bench sets the luma levels; the layer drives store_load.
*/
`timescale 1ns/1ns
module vkl_src_model #(
  parameter int FIELD = 40,
  parameter int LDLY  = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] fill_set,
  input  wire logic [9:0] key_set,
  input  wire logic [9:0] bg_set,
  input  wire logic       store_load,
  output logic            vblank,
  output logic [9:0]      fill_y,
  output logic [9:0]      key_y,
  output logic [9:0]      bg_y,
  output logic            load_done
);
  int fcnt;
  int lcnt;
  // ----------------------------------------
  // Field pulse, pixel levels, store
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt <= 0;
      lcnt <= 0;
      vblank <= 1'b0;
      load_done <= 1'b0;
    end else begin
      fcnt <= (fcnt == FIELD - 1) ? 0 : fcnt + 1;
      vblank <= (fcnt == FIELD - 1);
      lcnt <= store_load ? lcnt + 1 : 0;
      load_done <= store_load && (lcnt >= LDLY);
    end
  end
  always @(posedge clk) begin
    fill_y <= fill_set;
    key_y <= key_set;
    bg_y <= bg_set;
  end
endmodule
